// [logic/srsb_bus_if.sv]
`timescale 1ns/1ps
interface srsb_bus_if;
  logic cs_n;
  logic ck;
  logic ck_n;
  logic reset_n;
  logic [7:0] h_dq;
  logic h_dq_oe;
  logic h_read_write_strobe_mask;
  logic h_read_write_strobe_mask_oe;
  logic [7:0] d_dq;
  logic d_dq_oe;
  logic d_read_write_strobe_mask;
  logic d_read_write_strobe_mask_oe;
  logic [7:0] dq;
  logic read_write_strobe_mask;

  // released wire reads low; contention favours the device driver
  assign dq = d_dq_oe ? d_dq : (h_dq_oe ? h_dq : 8'h00);
  assign read_write_strobe_mask = d_read_write_strobe_mask_oe ? d_read_write_strobe_mask : (h_read_write_strobe_mask_oe ? h_read_write_strobe_mask : 1'b0);

  modport device (input cs_n, ck, ck_n, reset_n, dq, read_write_strobe_mask, output d_dq, d_dq_oe, d_read_write_strobe_mask, d_read_write_strobe_mask_oe);
  modport host (output cs_n, ck, ck_n, reset_n, h_dq, h_dq_oe, h_read_write_strobe_mask, h_read_write_strobe_mask_oe, input dq, read_write_strobe_mask);
endinterface : srsb_bus_if

// [logic/srsb_device.sv]
`timescale 1ns/1ps
module srsb_device
  import srsb_pkg::*;
#(
  parameter logic HOT_GRADE = 1'b0
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  srsb_bus_if.device bus,
  output logic sleep_o,
  output logic refresh_busy_o,
  output logic [12:0] refresh_row_o
);
  localparam int ROW_CYC = HOT_GRADE ? ROW_CYC_105 : ROW_CYC_85;
  localparam logic [7:0] TICK_LAST = 8'(ROW_CYC - 1);
  localparam logic [3:0] BUSY_LAST = 4'(REF_BUSY_CYC - 1);
  localparam logic [3:0] CA_LAST = 4'(CA_BYTES - 1);
  localparam logic [3:0] LAT1_LAST = 4'(LAT_EDGES - 1);
  localparam logic [3:0] LAT2_LAST = 4'(2 * LAT_EDGES - 1);
  localparam logic [15:0] CR1_RST = HOT_GRADE ? CR1_RESET_105 : CR1_RESET_85;

  typedef struct packed {
    logic [2:0] ck_s;
    logic [2:0] cs_s;
    logic [2:0] rs_s;
    logic [2:0] rw_s;
    logic [7:0] dq_s1;
    logic [7:0] dq_s2;
    logic [7:0] dq_s3;
    logic ck_q;
    logic cs_q;
    logic rs_q;
    srsb_dev_state_t st;
    logic [3:0] cnt;
    logic is_rd;
    logic is_reg;
    logic extra;
    logic bidx;
    logic [7:0] addr;
    logic [7:0] whi;
    logic [15:0] cr1;
    logic [7:0] tick;
    logic [3:0] bcnt;
    logic pend;
    logic busy;
    logic slp;
    logic [12:0] row;
    logic we;
    logic [7:0] waddr;
    logic [7:0] wdata;
    logic [7:0] dq;
    logic dq_oe;
    logic read_write_strobe_mask;
    logic read_write_strobe_mask_oe;
  } srsb_dev_reg_t;

  srsb_dev_reg_t r;
  srsb_dev_reg_t n;
  logic [7:0] mem [MEM_DEPTH];

  // a change counts once the second and third stages agree
  function automatic logic settle(input logic [2:0] c, input logic q);
    return (c[1] == c[2]) ? c[2] : q;
  endfunction : settle

  logic ck_edge;
  logic cs_fall;
  logic cs_rise;
  logic idle;
  logic row_due;
  logic active;
  logic [7:0] rbyte;

  always_comb begin
    n = r;
    n.we = 1'b0;
    n.ck_s = {r.ck_s[1:0], bus.ck};
    n.cs_s = {r.cs_s[1:0], bus.cs_n};
    n.rs_s = {r.rs_s[1:0], bus.reset_n};
    n.rw_s = {r.rw_s[1:0], bus.read_write_strobe_mask};
    n.dq_s1 = bus.dq;
    n.dq_s2 = r.dq_s1;
    n.dq_s3 = r.dq_s2;
    n.ck_q = settle(r.ck_s, r.ck_q);
    n.cs_q = settle(r.cs_s, r.cs_q);
    n.rs_q = settle(r.rs_s, r.rs_q);
    ck_edge = n.ck_q != r.ck_q;
    cs_fall = r.cs_q && !n.cs_q;
    cs_rise = !r.cs_q && n.cs_q;
    active = |(r.st & (DST_CA | DST_LAT | DST_RD | DST_WR));
    rbyte = r.is_reg ? (r.bidx ? r.cr1[7:0] : r.cr1[15:8]) : mem[r.addr];

    // refresh time base never looks at the bus clock
    row_due = r.tick == TICK_LAST;
    n.tick = row_due ? 8'h00 : r.tick + 8'h01;
    idle = ((r.st == DST_STBY) || (r.st == DST_SLEEP)) && r.cs_q;
    if (r.busy) begin
      if (r.bcnt == BUSY_LAST) begin
        n.busy = 1'b0;
      end else begin
        n.bcnt = r.bcnt + 4'h1;
      end
    end else if (r.pend && idle) begin
      n.pend = 1'b0;
      n.busy = 1'b1;
      n.bcnt = 4'h0;
      n.row = r.row + 13'h0001;
    end
    // a row falling due in the start cycle stays pending
    if (row_due) begin
      n.pend = 1'b1;
    end

    unique case (r.st)
      DST_STBY: begin
        n.dq_oe = 1'b0;
        n.read_write_strobe_mask_oe = 1'b0;
        if (cs_fall) begin
          n.st = DST_CA;
          n.cnt = 4'h0;
          n.extra = r.busy || r.pend;
          n.read_write_strobe_mask = r.busy || r.pend;
          n.read_write_strobe_mask_oe = 1'b1;
        end
      end
      DST_CA: begin
        if (ck_edge) begin
          n.cnt = r.cnt + 4'h1;
          if (r.cnt == 4'h0) begin
            n.is_rd = r.dq_s3[CA_RW_BIT];
            n.is_reg = r.dq_s3[CA_REG_BIT];
          end
          if (r.cnt == CA_LAST) begin
            n.addr = r.dq_s3;
            n.cnt = 4'h0;
            n.bidx = 1'b0;
            if (r.is_reg && !r.is_rd) begin
              n.st = DST_WR;
              n.read_write_strobe_mask_oe = 1'b0;
            end else begin
              n.st = DST_LAT;
              n.read_write_strobe_mask_oe = r.is_rd;
            end
          end
        end
      end
      DST_LAT: begin
        if (ck_edge) begin
          n.cnt = r.cnt + 4'h1;
          if (r.cnt == (r.extra ? LAT2_LAST : LAT1_LAST)) begin
            n.st = r.is_rd ? DST_RD : DST_WR;
            n.cnt = 4'h0;
          end
        end
      end
      DST_RD: begin
        if (ck_edge) begin
          n.dq = rbyte;
          n.dq_oe = 1'b1;
          n.read_write_strobe_mask = !r.read_write_strobe_mask;
          n.bidx = !r.bidx;
          if (!r.is_reg) begin
            n.addr = r.addr + 8'h01;
          end
        end
      end
      DST_WR: begin
        if (ck_edge) begin
          if (r.is_reg) begin
            // register writes take every byte whatever the strobe shows
            n.bidx = !r.bidx;
            if (!r.bidx) begin
              n.whi = r.dq_s3;
            end else begin
              n.cr1 = {r.whi, r.dq_s3[7:2], r.cr1[1:0]};
            end
          end else begin
            n.we = !r.rw_s[2];
            n.waddr = r.addr;
            n.wdata = r.dq_s3;
            n.addr = r.addr + 8'h01;
          end
        end
      end
      DST_SLEEP: begin
        n.dq_oe = 1'b0;
        n.read_write_strobe_mask_oe = 1'b0;
        if (cs_fall) begin
          n.cr1[CR1_SLEEP_BIT] = 1'b0;
          n.st = DST_WAKE;
        end
      end
      DST_WAKE: begin
        if (cs_rise) begin
          n.st = DST_STBY;
        end
      end
    endcase

    if (active && cs_rise) begin
      n.st = r.cr1[CR1_SLEEP_BIT] ? DST_SLEEP : DST_STBY;
      n.dq_oe = 1'b0;
      n.read_write_strobe_mask_oe = 1'b0;
    end

    // reset pin: defaults back, refresh halted, array may decay
    if (!r.rs_q) begin
      n.st = DST_STBY;
      n.cr1 = CR1_RST;
      n.dq_oe = 1'b0;
      n.read_write_strobe_mask_oe = 1'b0;
      n.tick = 8'h00;
      n.pend = 1'b0;
      n.busy = 1'b0;
      n.we = 1'b0;
    end
    n.slp = n.st == DST_SLEEP;

    if (srst_i) begin
      n = '0;
      n.cs_s = 3'h7;
      n.cs_q = 1'b1;
      n.st = DST_STBY;
      n.cr1 = CR1_RST;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    r <= n;
  end

  // array write is one cycle behind the bus clock edge
  always_ff @(posedge ref_clk_i) begin
    if (r.we) begin
      mem[r.waddr] <= r.wdata;
    end
  end

  assign bus.d_dq = r.dq;
  assign bus.d_dq_oe = r.dq_oe;
  assign bus.d_read_write_strobe_mask = r.read_write_strobe_mask;
  assign bus.d_read_write_strobe_mask_oe = r.read_write_strobe_mask_oe;
  assign sleep_o = r.slp;
  assign refresh_busy_o = r.busy;
  assign refresh_row_o = r.row;
endmodule : srsb_device

// [logic/srsb_host.sv]
`timescale 1ns/1ps
module srsb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [$clog2(DEPTH):0] level_o
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } srsb_fifo_reg_t;
  srsb_fifo_reg_t r;
  srsb_fifo_reg_t n;

  always_comb begin
    n = r;
    level_o = r.wp - r.rp;
    in_ready_o = level_o != (AW + 1)'(DEPTH);
    out_valid_o = r.wp != r.rp;
    out_data_o = r.mem[r.rp[AW-1:0]];
    if (in_valid_i && in_ready_o) begin
      n.mem[r.wp[AW-1:0]] = in_data_i;
      n.wp = r.wp + 1'b1;
    end
    if (out_valid_o && out_ready_i) begin
      n.rp = r.rp + 1'b1;
    end
    if (srst_i) begin
      n = '0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    r <= n;
  end
endmodule : srsb_fifo

module srsb_host
  import srsb_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic srst_i,
  srsb_bus_if.host bus,
  input wire logic hw_reset_i,
  input wire logic [1:0] refresh_code_i,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic cmd_write_i,
  input wire logic cmd_reg_i,
  input wire logic [7:0] cmd_addr_i,
  input wire logic [7:0] cmd_len_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_valid_i,
  output logic wr_ready_o,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  input wire logic rd_ready_i,
  output logic busy_o
);
  localparam logic [2:0] PREP = 3'(PREP_DIV);
  localparam logic [2:0] EDGE = 3'(HALF_CYC - 1);
  localparam logic [3:0] CA_LAST = 4'(CA_BYTES - 1);
  localparam logic [3:0] CA_ADDR = 4'(CA_ADDR_BYTE);
  localparam logic [3:0] LAT1_LAST = 4'(LAT_EDGES - 1);
  localparam logic [3:0] LAT2_LAST = 4'(2 * LAT_EDGES - 1);
  localparam logic [6:0] LIM_LONG = 7'(MAX_SELECT_LOW_TIME_85_CYC - SPLIT_MARGIN);
  localparam logic [6:0] LIM_SHORT = 7'(MAX_SELECT_LOW_TIME_105_CYC - SPLIT_MARGIN);

  typedef struct packed {
    srsb_host_state_t st;
    logic [2:0] div;
    logic cs_n;
    logic ck;
    logic ckn;
    logic rst_n;
    logic [7:0] dq;
    logic dq_oe;
    logic read_write_strobe_mask;
    logic read_write_strobe_mask_oe;
    logic [2:0] rw_s;
    logic rw_q;
    logic [7:0] dq_s1;
    logic [7:0] dq_s2;
    logic [7:0] dq_s3;
    logic [3:0] cnt;
    logic is_wr;
    logic is_reg;
    logic extra;
    logic [7:0] addr;
    logic [7:0] len;
    logic [7:0] sent;
    logic [7:0] recv;
    logic [7:0] took;
    logic [7:0] wbuf;
    logic wfull;
    logic wrdy;
    logic cmd_rdy;
    logic busy;
    logic [6:0] csc;
  } srsb_host_reg_t;
  srsb_host_reg_t r;
  srsb_host_reg_t n;

  logic push;
  logic fifo_rdy;
  logic [3:0] level;
  logic prep;
  logic edge_now;
  logic go;
  logic room;
  logic [6:0] lim;
  logic [7:0] ca_byte;

  srsb_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) srsb_fifo_i (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .in_data_i(r.dq_s3),
    .in_valid_i(push),
    .in_ready_o(fifo_rdy),
    .out_data_o(rd_data_o),
    .out_valid_o(rd_valid_o),
    .out_ready_i(rd_ready_i),
    .level_o(level)
  );

  always_comb begin
    n = r;
    push = 1'b0;
    go = 1'b1;
    n.rst_n = !hw_reset_i;
    n.rw_s = {r.rw_s[1:0], bus.read_write_strobe_mask};
    n.dq_s1 = bus.dq;
    n.dq_s2 = r.dq_s1;
    n.dq_s3 = r.dq_s2;
    n.rw_q = (r.rw_s[1] == r.rw_s[2]) ? r.rw_s[2] : r.rw_q;
    // each strobe change is one byte; bytes past the request are dropped
    if ((r.st == HST_RD || r.st == HST_END) && !r.is_wr && n.rw_q != r.rw_q && r.recv != r.sent) begin
      push = fifo_rdy;
      n.recv = r.recv + 8'h01;
    end
    n.csc = r.cs_n ? 7'h00 : ((r.csc == 7'h7f) ? r.csc : r.csc + 7'h01);
    lim = (refresh_code_i == INTV_4US) ? LIM_LONG : LIM_SHORT;
    room = {4'h0, 4'(FIFO_DEPTH) - level} >= (r.sent - r.recv) + 8'h02;
    ca_byte = (r.cnt == 4'h0) ? {!r.is_wr, r.is_reg, 6'h00} : ((r.cnt == CA_ADDR) ? r.addr : 8'h00);
    prep = r.div == PREP;
    edge_now = r.div == EDGE;
    if (wr_valid_i && r.wrdy) begin
      n.wbuf = wr_data_i;
      n.wfull = 1'b1;
      n.took = r.took + 8'h01;
    end

    unique case (r.st)
      HST_IDLE: begin
        go = 1'b0;
        if (cmd_valid_i && r.cmd_rdy) begin
          n.st = HST_CA;
          n.cs_n = 1'b0;
          n.is_wr = cmd_write_i;
          n.is_reg = cmd_reg_i;
          n.addr = cmd_addr_i;
          n.len = cmd_len_i;
          n.cnt = 4'h0;
          n.sent = 8'h00;
          n.recv = 8'h00;
          n.took = 8'h00;
          n.div = 3'h0;
        end
      end
      HST_CA: begin
        if (prep) begin
          n.dq = ca_byte;
          n.dq_oe = 1'b1;
        end
        if (edge_now) begin
          n.cnt = r.cnt + 4'h1;
          if (r.cnt == CA_LAST) begin
            n.extra = r.rw_q;
            n.cnt = 4'h0;
            n.st = (r.is_wr && r.is_reg) ? HST_WR : HST_LAT;
          end
        end
      end
      HST_LAT: begin
        if (prep) begin
          n.dq_oe = 1'b0;
          n.read_write_strobe_mask_oe = 1'b0;
        end
        if (edge_now) begin
          n.cnt = r.cnt + 4'h1;
          if (r.cnt == (r.extra ? LAT2_LAST : LAT1_LAST)) begin
            n.st = r.is_wr ? HST_WR : HST_RD;
          end
        end
      end
      HST_RD, HST_WR: begin
        if (prep) begin
          if (!r.ck && (r.sent == r.len || (r.sent >= 8'h02 && r.csc >= lim))) begin
            n.st = HST_END;
            n.cnt = 4'h0;
            go = 1'b0;
          end else if (!r.ck && r.sent != r.len && (r.is_wr ? !r.wfull : !room)) begin
            go = 1'b0;
            // a stall may not outlive the select-low limit, even with nothing sent yet
            if (r.csc >= lim) begin
              n.st = HST_END;
              n.cnt = 4'h0;
            end
          end else if (r.is_wr) begin
            n.dq = r.wbuf;
            n.dq_oe = 1'b1;
            n.read_write_strobe_mask = !(r.wfull && r.sent != r.len);
            n.read_write_strobe_mask_oe = !r.is_reg;
            if (r.sent != r.len) begin
              n.wfull = 1'b0;
            end
          end
        end
        if (edge_now && r.sent != r.len) begin
          n.sent = r.sent + 8'h01;
        end
      end
      HST_END: begin
        go = 1'b0;
        if (prep) begin
          n.dq_oe = 1'b0;
          n.read_write_strobe_mask_oe = 1'b0;
          if (r.is_wr || r.recv == r.sent) begin
            n.cs_n = 1'b1;
          end
        end
        if (edge_now && r.cs_n) begin
          n.cnt = r.cnt + 4'h1;
          if (r.cnt != 4'h0) begin
            n.len = r.len - r.sent;
            n.addr = r.addr + r.sent;
            n.took = r.took - r.sent;
            n.sent = 8'h00;
            n.recv = 8'h00;
            n.cnt = 4'h0;
            n.st = (r.len == r.sent) ? HST_IDLE : HST_CA;
            n.cs_n = r.len == r.sent;
          end
        end
      end
      default: begin
        n.st = HST_IDLE;
      end
    endcase

    // hold the divider at the decision point while stalled
    if (r.st != HST_IDLE) begin
      if (prep && !go && r.st != HST_END) begin
        n.div = r.div;
      end else begin
        n.div = edge_now ? 3'h0 : r.div + 3'h1;
      end
    end
    if (edge_now && (r.st == HST_CA || r.st == HST_LAT || r.st == HST_RD || r.st == HST_WR)) begin
      n.ck = !r.ck;
      n.ckn = r.ck;
    end
    n.cmd_rdy = n.st == HST_IDLE;
    n.busy = n.st != HST_IDLE;
    n.wrdy = !n.wfull && n.is_wr && (n.st == HST_LAT || n.st == HST_WR || n.st == HST_CA) && n.took != n.len;

    if (srst_i) begin
      n = '0;
      n.st = HST_IDLE;
      n.cs_n = 1'b1;
      n.ckn = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    r <= n;
  end

  assign bus.cs_n = r.cs_n;
  assign bus.ck = r.ck;
  assign bus.ck_n = r.ckn;
  assign bus.reset_n = r.rst_n;
  assign bus.h_dq = r.dq;
  assign bus.h_dq_oe = r.dq_oe;
  assign bus.h_read_write_strobe_mask = r.read_write_strobe_mask;
  assign bus.h_read_write_strobe_mask_oe = r.read_write_strobe_mask_oe;
  assign cmd_ready_o = r.cmd_rdy;
  assign wr_ready_o = r.wrdy;
  assign busy_o = r.busy;
endmodule : srsb_host

// [logic/srsb_pkg.sv]
// How it works
// - config bit five set enters retention sleep
// - falling select wakes device, clears sleep bit
// - any reset leaves sleep, stops refresh
// - refresh only starts between host accesses
// - strobe high in address phase if refreshing
// - single rows spread evenly over interval
// - all rows within 64 or 16 ms
// - host starts ending transaction one bus clock before select-low limit
// - select-low limit is half row interval
// - host splits long bursts at the limit
// - interval code readable in config bits one:zero
// - data and strobe released when not transferring
// - host drives address phase, releases for reads
// - device drives read data, host writes with mask
// - paused bus clock rests true low
// - device drives strobe in address phase, except when that select wakes it from sleep
// - host never drives strobe in zero-latency writes
// - zero-latency writes ignore mask, write all bytes
package srsb_pkg;
  localparam int CLK_NS = 50;
  localparam int ARRAY_ROWS = 8192;
  localparam int REF_WIN_85_MS = 64;
  localparam int REF_WIN_105_MS = 16;
  localparam int ROW_CYC_85 = (REF_WIN_85_MS * 1000000) / (ARRAY_ROWS * CLK_NS);
  localparam int ROW_CYC_105 = (REF_WIN_105_MS * 1000000) / (ARRAY_ROWS * CLK_NS);
  localparam int REF_BUSY_NS = 100;
  localparam int REF_BUSY_CYC = (REF_BUSY_NS + CLK_NS - 1) / CLK_NS;
  localparam int MAX_SELECT_LOW_TIME_85_US = 4;
  localparam int MAX_SELECT_LOW_TIME_105_US = 1;
  localparam int MAX_SELECT_LOW_TIME_85_CYC = (MAX_SELECT_LOW_TIME_85_US * 1000) / CLK_NS;
  localparam int MAX_SELECT_LOW_TIME_105_CYC = (MAX_SELECT_LOW_TIME_105_US * 1000) / CLK_NS;
  localparam int HALF_CYC = 4;
  localparam int PREP_DIV = 1;
  localparam int SPLIT_MARGIN = 2 * HALF_CYC;
  localparam int CA_BYTES = 6;
  localparam int CA_RW_BIT = 7;
  localparam int CA_REG_BIT = 6;
  localparam int CA_ADDR_BYTE = 5;
  localparam int LAT_EDGES = 6;
  localparam int MEM_DEPTH = 256;
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int CR1_SLEEP_BIT = 5;
  localparam logic [1:0] INTV_4US = 2'h1;
  localparam logic [1:0] INTV_1US = 2'h2;
  localparam logic [15:0] CR1_RESET_85 = 16'hffc1;
  localparam logic [15:0] CR1_RESET_105 = 16'hffc2;

  typedef enum logic [6:0] {
    DST_STBY = 7'h01,
    DST_CA = 7'h02,
    DST_LAT = 7'h04,
    DST_RD = 7'h08,
    DST_WR = 7'h10,
    DST_SLEEP = 7'h20,
    DST_WAKE = 7'h40
  } srsb_dev_state_t;

  typedef enum logic [5:0] {
    HST_IDLE = 6'h01,
    HST_CA = 6'h02,
    HST_LAT = 6'h04,
    HST_RD = 6'h08,
    HST_WR = 6'h10,
    HST_END = 6'h20
  } srsb_host_state_t;
endpackage : srsb_pkg

// [tb/srsb_link_properties.sv]
`timescale 1ns/1ps
module srsb_link_properties
  import srsb_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic cs_n,
  input wire logic ck,
  input wire logic ck_n,
  input wire logic reset_n,
  input wire logic h_dq_oe,
  input wire logic h_read_write_strobe_mask_oe,
  input wire logic d_dq_oe,
  input wire logic d_read_write_strobe_mask_oe,
  input wire logic sleep_o,
  input wire logic refresh_busy_o,
  input wire logic [12:0] refresh_row_o
);
  // slack covers one select-low stretch delaying a due row refresh
  localparam int GAP_MAX = ROW_CYC_85 + 250;
  int gap;
  int low_run;

  always_ff @(posedge ref_clk_i) begin
    gap <= (srst_i || !reset_n || refresh_busy_o) ? 0 : gap + 1;
    low_run <= cs_n ? 0 : low_run + 1;
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (srst_i);

  property p_ck_pair;
    ck_n == !ck;
  endproperty
  a_ck_pair: assert property (p_ck_pair) else $error("bus clock pair not complementary");
  property p_host_ca_drive;
    $fell(cs_n) |-> ##[0:2] h_dq_oe;
  endproperty
  a_host_ca_drive: assert property (p_host_ca_drive) else $error("host not driving address phase");
  property p_dq_single;
    !(h_dq_oe && d_dq_oe);
  endproperty
  a_dq_single: assert property (p_dq_single) else $error("both ends drive data lines");
  property p_read_write_strobe_mask_single;
    !(h_read_write_strobe_mask_oe && d_read_write_strobe_mask_oe);
  endproperty
  a_read_write_strobe_mask_single: assert property (p_read_write_strobe_mask_single) else $error("both ends drive strobe");
  property p_ca_strobe;
    !sleep_o && $fell(cs_n) ##1 (!cs_n)[*8] |-> d_read_write_strobe_mask_oe;
  endproperty
  a_ca_strobe: assert property (p_ca_strobe) else $error("strobe not driven in address phase");
  property p_idle_release;
    cs_n[*8] |-> !d_dq_oe && !d_read_write_strobe_mask_oe;
  endproperty
  a_idle_release: assert property (p_idle_release) else $error("device drives while deselected");
  property p_reset_release;
    (!reset_n)[*6] |-> !d_dq_oe && !d_read_write_strobe_mask_oe && !sleep_o;
  endproperty
  a_reset_release: assert property (p_reset_release) else $error("device active in pin reset");
  property p_wake;
    sleep_o && $fell(cs_n) |-> ##[1:8] !sleep_o;
  endproperty
  a_wake: assert property (p_wake) else $error("select low did not wake");
  property p_refresh_idle;
    $rose(refresh_busy_o) |-> low_run < 8;
  endproperty
  a_refresh_idle: assert property (p_refresh_idle) else $error("refresh began inside access");
  property p_refresh_gap;
    gap < GAP_MAX;
  endproperty
  a_refresh_gap: assert property (p_refresh_gap) else $error("row refresh overdue");
  property p_row_step;
    !$stable(refresh_row_o) |-> refresh_row_o == $past(refresh_row_o) + 13'h1 || refresh_row_o == 13'h0;
  endproperty
  a_row_step: assert property (p_row_step) else $error("row counter skipped");
endmodule : srsb_link_properties

// [tb/srsb_tb_top.sv]
`timescale 1ns/1ps
module srsb_tb_top
  import srsb_pkg::*;
;
  logic ref_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic hw_reset_i = 1'b0;
  logic [1:0] refresh_code_i = 2'h0;
  logic cmd_valid_i = 1'b0;
  logic cmd_write_i = 1'b0;
  logic cmd_reg_i = 1'b0;
  logic [7:0] cmd_addr_i = 8'h00;
  logic [7:0] cmd_len_i = 8'h01;
  logic [7:0] wr_data_i = 8'h00;
  logic wr_valid_i = 1'b0;
  logic rd_ready_i = 1'b0;
  logic cmd_ready_o, wr_ready_o, rd_valid_o, busy_o, sleep_o, refresh_busy_o;
  logic [7:0] rd_data_o;
  logic [12:0] refresh_row_o;
  logic [7:0] mem_model [256];
  logic [7:0] wq [$];
  logic [7:0] rq [$];
  logic [15:0] sleep_val;
  logic [7:0] a;
  int n;
  int err_total = 0;
  int cmp_count = 0;
  int seed = 1;
  int stall = 0;

  srsb_bus_if bus_if ();
  srsb_device #(.HOT_GRADE(1'b0)) srsb_device_i (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .bus(bus_if.device),
    .sleep_o(sleep_o), .refresh_busy_o(refresh_busy_o), .refresh_row_o(refresh_row_o));
  srsb_host srsb_host_i (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .bus(bus_if.host), .hw_reset_i(hw_reset_i),
    .refresh_code_i(refresh_code_i), .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .cmd_write_i(cmd_write_i),
    .cmd_reg_i(cmd_reg_i), .cmd_addr_i(cmd_addr_i), .cmd_len_i(cmd_len_i), .wr_data_i(wr_data_i),
    .wr_valid_i(wr_valid_i), .wr_ready_o(wr_ready_o), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
    .rd_ready_i(rd_ready_i), .busy_o(busy_o));
  srsb_link_properties srsb_link_properties_i (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .cs_n(bus_if.cs_n),
    .ck(bus_if.ck), .ck_n(bus_if.ck_n), .reset_n(bus_if.reset_n), .h_dq_oe(bus_if.h_dq_oe),
    .h_read_write_strobe_mask_oe(bus_if.h_read_write_strobe_mask_oe), .d_dq_oe(bus_if.d_dq_oe), .d_read_write_strobe_mask_oe(bus_if.d_read_write_strobe_mask_oe), .sleep_o(sleep_o),
    .refresh_busy_o(refresh_busy_o), .refresh_row_o(refresh_row_o));

  initial begin
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t byte %h expected %h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic chk_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t sleep flag %b expected %b", $time, got, exp);
    end
  endtask : chk_bit

  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  // one command: write bytes come from wq, read bytes land in rq
  task automatic xfer(input logic w, input logic r, input logic [7:0] ad, input int len);
    int guard;
    int since;
    guard = 0;
    since = -1;
    rq.delete();
    cmd_valid_i <= 1'b1;
    cmd_write_i <= w;
    cmd_reg_i <= r;
    cmd_addr_i <= ad;
    cmd_len_i <= len[7:0];
    wr_valid_i <= w;
    wr_data_i <= w ? wq[0] : 8'h00;
    forever begin
      @(posedge ref_clk_i);
      guard++;
      if (since >= 0) since++;
      if (cmd_valid_i && cmd_ready_o === 1'b1) begin
        cmd_valid_i <= 1'b0;
        since = 0;
      end
      if (wr_valid_i && wr_ready_o === 1'b1) void'(wq.pop_front());
      if (rd_valid_o === 1'b1 && rd_ready_i) rq.push_back(rd_data_o);
      // leave before driving, so the next call never drives twice in one step
      if (since > 3 && busy_o === 1'b0 && (w || rq.size() >= len)) break;
      if (guard > 4000) begin
        err_total++;
        $display("[FAIL] %0t transfer hung", $time);
        break;
      end
      // valid is held without gaps so the host never sends a masked hole
      wr_valid_i <= w && wq.size() > 0;
      wr_data_i <= (wq.size() > 0) ? wq[0] : 8'($random(seed));
      if (stall > 0) stall--;
      rd_ready_i <= stall == 0 && ($random(seed) & 3) != 0;
    end
  endtask : xfer

  task automatic mem_write(input logic [7:0] ad, input int len, input logic keep);
    wq.delete();
    for (int i = 0; i < len; i++) begin
      wq.push_back(8'($random(seed)));
      if (keep) mem_model[ad + i] = wq[i];
    end
    xfer(1'b1, 1'b0, ad, len);
  endtask : mem_write

  task automatic mem_read(input logic [7:0] ad, input int len);
    xfer(1'b0, 1'b0, ad, len);
    for (int i = 0; i < len; i++) chk_byte(rq[i], mem_model[ad + i]);
  endtask : mem_read

  task automatic reg_access(input logic w, input logic [15:0] v);
    wq = '{v[15:8], v[7:0]};
    xfer(w, 1'b1, 8'($random(seed)), 2);
    if (!w) chk_byte(rq[0], v[15:8]);
    if (!w) chk_byte(rq[1], v[7:0]);
  endtask : reg_access

  task automatic wait_sleep;
    int g;
    g = 0;
    while (sleep_o !== 1'b1 && g < 200) begin
      @(posedge ref_clk_i);
      g++;
    end
    chk_bit(sleep_o, 1'b1);
  endtask : wait_sleep

  initial begin
    sleep_val = CR1_RESET_85 | (16'h1 << CR1_SLEEP_BIT);
    repeat (20) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    repeat (10) @(posedge ref_clk_i);
    reg_access(1'b0, CR1_RESET_85);
    refresh_code_i <= rq[1][1:0];
    for (int k = 0; k < 12; k++) begin
      a = 8'($random(seed)) & 8'h7f;
      n = ($random(seed) & 15) + 1;
      mem_write(a, n, 1'b1);
      mem_read(a, n);
    end
    mem_write(8'h80, 12, 1'b1);
    // reader stalls long enough for the read buffer to fill and hold the bus
    stall = 120;
    mem_read(8'h80, 12);
    reg_access(1'b1, sleep_val);
    wait_sleep();
    mem_write(8'h80, 2, 1'b0);
    chk_bit(sleep_o, 1'b0);
    reg_access(1'b0, CR1_RESET_85);
    mem_read(8'h80, 12);
    reg_access(1'b1, sleep_val);
    wait_sleep();
    hw_reset_i <= 1'b1;
    repeat (10) @(posedge ref_clk_i);
    hw_reset_i <= 1'b0;
    repeat (10) @(posedge ref_clk_i);
    chk_bit(sleep_o, 1'b0);
    reg_access(1'b0, CR1_RESET_85);
    report_and_stop();
  end

  initial begin
    #(40000 * 50);
    err_total++;
    $display("[FAIL] %0t watchdog expired", $time);
    report_and_stop();
  end
endmodule : srsb_tb_top
